// file: design/ccum_pkg.sv
// Constants for the controller's upper register map and reset values
package ccum_pkg;
    localparam int          ADDR_W          = 8;
    localparam int          DATA_W          = 8;
    localparam int          RAM_DEPTH       = 80;
    localparam logic [6:0]  OFS_MODE        = 7'h00;
    localparam logic [6:0]  OFS_CMD         = 7'h01;
    localparam logic [6:0]  OFS_STATE       = 7'h02;
    localparam logic [6:0]  OFS_FLAGS       = 7'h03;
    localparam logic [6:0]  OFS_TXB_RD_LO   = 7'h1B;
    localparam logic [6:0]  OFS_TXB_RD_HI   = 7'h1C;
    localparam logic [6:0]  OFS_MSG_COUNT   = 7'h1D;
    localparam logic [6:0]  OFS_RXB_START   = 7'h1E;
    localparam logic [6:0]  OFS_CLKDIV      = 7'h1F;
    localparam logic [6:0]  OFS_RAM_LO      = 7'h20;
    localparam logic [6:0]  OFS_RAM_HI      = 7'h6F;
    localparam logic [6:0]  RAM_TX_BASE     = 7'h40;
    localparam logic [6:0]  TX_DATA7_INDEX  = 7'h0B;
    localparam logic [7:0]  MODE_RESET      = 8'h01;
    localparam logic [7:0]  MODE_KEEP_MASK  = 8'h0E;
    localparam logic [7:0]  STATE_RESET     = 8'h3C;
    localparam logic [7:0]  STATE_KEEP_MASK = 8'hC8;
    localparam logic [7:0]  FLAGS_KEEP_MASK = 8'h04;
    localparam logic [7:0]  CLKDIV_LOCKED   = 8'hE8;
    localparam logic [7:0]  RXB_START_RESET = 8'h00;
    localparam logic [7:0]  CLKDIV_RESET    = 8'h00;
    localparam int          MODE_INIT_BIT   = 0;
    localparam int          MODE_SLEEP_BIT  = 4;
    localparam int          FRAME_LONG_BIT  = 7;
endpackage : ccum_pkg

// file: design/ccum_regmap.sv
// Upper register map, internal RAM window and reset handling of the controller
`timescale 1ns/1ps
module ccum_regmap
    import ccum_pkg::*;
#(
    parameter int RAM_WORDS = ccum_pkg::RAM_DEPTH
) (
    input  wire logic                      ref_clk_in,
    input  wire logic                      sys_rst_in,
    input  wire logic                      clk_en_in,
    input  wire logic                      host_cs_in,
    input  wire logic                      host_wr_in,
    input  wire logic                      host_rd_in,
    input  wire logic [ccum_pkg::ADDR_W-1:0] host_addr_in,
    input  wire logic [ccum_pkg::DATA_W-1:0] host_wdata_in,
    input  wire logic                      bus_off_in,
    input  wire logic [7:0]                core_state_in,
    input  wire logic [7:0]                core_flags_in,
    input  wire logic [6:0]                rx_read_ptr_in,
    input  wire logic [6:0]                rx_msg_len_in,
    input  wire logic [7:0]                rx_msg_count_in,
    input  wire logic                      core_ram_we_in,
    input  wire logic [6:0]                core_ram_addr_in,
    input  wire logic [7:0]                core_ram_wdata_in,
    output logic [ccum_pkg::DATA_W-1:0]    host_rdata_out,
    output logic                           host_rvalid_out,
    output logic [7:0]                     operating_config_out,
    output logic [7:0]                     command_strobe_out,
    output logic [7:0]                     rx_buffer_start_out,
    output logic [7:0]                     clock_divider_out,
    output logic                           init_hold_out,
    output logic                           frame_abort_out,
    output logic                           resume_out
);
    import ccum_pkg::*;

    logic [7:0] ram [RAM_WORDS];
    logic [7:0] operating_config_reg;
    logic [7:0] state_reg;
    logic [7:0] event_flags_reg;
    logic [7:0] rx_buffer_start;
    logic [7:0] clock_divider_cfg;
    logic       init_prev;
    logic [6:0] loc;
    logic       wr_hit;
    logic       rd_hit;
    logic       init_hold;
    logic       enter_init;
    logic       long_frame_format;
    logic       ram_win;
    logic [6:0] ram_idx;
    logic [6:0] fifo_idx;
    logic [7:0] next_rdata;

    function automatic logic [6:0] fifo_wrap(input logic [6:0] a);
        fifo_wrap = (a >= 7'd64) ? 7'(a - 7'd64) : a;
    endfunction : fifo_wrap

    assign loc               = host_addr_in[6:0];
    assign wr_hit            = host_cs_in && host_wr_in;
    assign rd_hit            = host_cs_in && host_rd_in;
    assign init_hold         = operating_config_reg[MODE_INIT_BIT];
    assign long_frame_format = ram[rx_read_ptr_in[5:0]][FRAME_LONG_BIT];
    assign ram_win           = (loc >= OFS_RAM_LO) && (loc <= OFS_RAM_HI);
    assign ram_idx           = 7'(loc - OFS_RAM_LO);
    // Behind-message bytes: current message start plus its length, wrapped in the FIFO
    assign fifo_idx          = fifo_wrap(7'(rx_read_ptr_in + rx_msg_len_in
                                          + 7'(loc - OFS_TXB_RD_LO)));
    // Bus-off forces reset entry, keeps mode bits 3:1 and wins over a host write in the same cycle
    assign enter_init        = bus_off_in && !init_hold;

    // Mode register
    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            operating_config_reg <= MODE_RESET;
        end else if (clk_en_in) begin
            if (enter_init) begin
                operating_config_reg <= (operating_config_reg & MODE_KEEP_MASK) | MODE_RESET;
            end else if (wr_hit && loc == OFS_MODE) begin
                // Sleep cannot be requested together with init-hold
                operating_config_reg <= {3'b000,
                    host_wdata_in[MODE_SLEEP_BIT] & ~host_wdata_in[MODE_INIT_BIT],
                    host_wdata_in[3:0]};
            end
        end
    end

    // Command strobes last one cycle; writes ignored in reset mode
    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            command_strobe_out <= 8'h00;
        end else if (clk_en_in) begin
            if (wr_hit && loc == OFS_CMD && !init_hold && !enter_init) begin
                command_strobe_out <= {3'b000, host_wdata_in[4:0]};
            end else begin
                command_strobe_out <= 8'h00;
            end
        end
    end

    // Status and flag mirrors; reset entry overrides volatile bits
    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            state_reg       <= STATE_RESET;
            event_flags_reg <= 8'h00;
        end else if (clk_en_in) begin
            if (init_hold) begin
                state_reg       <= (state_reg & STATE_KEEP_MASK) | (STATE_RESET & ~STATE_KEEP_MASK);
                event_flags_reg <= event_flags_reg & FLAGS_KEEP_MASK;
            end else begin
                state_reg       <= core_state_in;
                // Set wins over the read-clear
                event_flags_reg <= core_flags_in |
                    ((rd_hit && loc == OFS_FLAGS) ? 8'h00 : event_flags_reg);
            end
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            rx_buffer_start <= RXB_START_RESET;
        end else if (clk_en_in && wr_hit && loc == OFS_RXB_START && init_hold) begin
            rx_buffer_start <= host_wdata_in;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            clock_divider_cfg <= CLKDIV_RESET;
        end else if (clk_en_in && wr_hit && loc == OFS_CLKDIV) begin
            if (init_hold) begin
                clock_divider_cfg <= host_wdata_in;
            end else begin
                clock_divider_cfg <= (clock_divider_cfg & CLKDIV_LOCKED)
                                   | (host_wdata_in & ~CLKDIV_LOCKED);
            end
        end
    end

    // RAM has no reset; contents are arbitrary after power-up
    always_ff @(posedge ref_clk_in) begin
        if (clk_en_in) begin
            if (wr_hit && ram_win && init_hold) begin
                ram[ram_idx] <= host_wdata_in;
            end else if (wr_hit && !init_hold && long_frame_format
                         && (loc == OFS_TXB_RD_LO || loc == OFS_TXB_RD_HI)) begin
                ram[7'(RAM_TX_BASE + TX_DATA7_INDEX + 7'(loc - OFS_TXB_RD_LO))] <= host_wdata_in;
            end else if (core_ram_we_in) begin
                ram[core_ram_addr_in] <= core_ram_wdata_in;
            end
        end
    end

    always_comb begin
        next_rdata = 8'h00;
        if (loc == OFS_MODE) begin
            next_rdata = operating_config_reg;
        end else if (loc == OFS_STATE) begin
            next_rdata = state_reg;
        end else if (loc == OFS_FLAGS) begin
            next_rdata = event_flags_reg;
        end else if (loc == OFS_TXB_RD_LO || loc == OFS_TXB_RD_HI) begin
            // Long frames read received data 7/8, which also sit behind the header
            if (!init_hold) begin
                next_rdata = ram[fifo_wrap(long_frame_format ?
                    7'(rx_read_ptr_in + 7'd11 + 7'(loc - OFS_TXB_RD_LO)) : fifo_idx)];
            end
        end else if (loc == OFS_MSG_COUNT) begin
            next_rdata = rx_msg_count_in;
        end else if (loc == OFS_RXB_START) begin
            next_rdata = rx_buffer_start;
        end else if (loc == OFS_CLKDIV) begin
            next_rdata = clock_divider_cfg;
        end else if (ram_win) begin
            next_rdata = ram[ram_idx];
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            host_rdata_out  <= 8'h00;
            host_rvalid_out <= 1'b0;
        end else if (clk_en_in) begin
            host_rvalid_out <= rd_hit;
            if (rd_hit) begin
                host_rdata_out <= next_rdata;
            end
        end
    end

    // Mode transition pulses toward the protocol engine
    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            init_prev       <= 1'b1;
            frame_abort_out <= 1'b0;
            resume_out      <= 1'b0;
        end else if (clk_en_in) begin
            init_prev       <= init_hold;
            frame_abort_out <= init_hold && !init_prev;
            resume_out      <= !init_hold && init_prev;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            operating_config_out <= MODE_RESET;
            init_hold_out        <= 1'b1;
            rx_buffer_start_out  <= RXB_START_RESET;
            clock_divider_out    <= CLKDIV_RESET;
        end else if (clk_en_in) begin
            operating_config_out <= operating_config_reg;
            init_hold_out        <= init_hold;
            rx_buffer_start_out  <= rx_buffer_start;
            clock_divider_out    <= clock_divider_cfg;
        end
    end
endmodule : ccum_regmap

// file: testbench/ccum_host_model.sv
// Host CPU model making single-byte accesses on the parallel bus
`timescale 1ns/1ps
module ccum_host_model (
    input  wire logic       ref_clk_in,
    input  wire logic [7:0] host_rdata_in,
    output logic            host_cs_out,
    output logic            host_wr_out,
    output logic            host_rd_out,
    output logic [7:0]      host_addr_out,
    output logic [7:0]      host_wdata_out
);
    initial begin
        {host_cs_out, host_wr_out, host_rd_out, host_addr_out, host_wdata_out} = '0;
    end
    // Callers never address the production test register
    task xfer(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
        @(posedge ref_clk_in);
        host_cs_out <= 1'b1;
        host_wr_out <= w;
        host_rd_out <= !w;
        host_addr_out <= a;
        host_wdata_out <= d;
        @(posedge ref_clk_in);
        {host_cs_out, host_wr_out, host_rd_out} <= 3'b000;
        // Released lines show the inverse so stale values cannot pass
        host_addr_out <= ~a;
        host_wdata_out <= ~d;
        @(posedge ref_clk_in);
        #1 q = host_rdata_in;
    endtask : xfer
endmodule : ccum_host_model

// file: testbench/ccum_regmap_chk.sv
// Port-level assertions of the upper register map
`timescale 1ns/1ps
module ccum_regmap_chk
    import ccum_pkg::*;
(
    input wire logic       ref_clk_in,
    input wire logic       sys_rst_in,
    input wire logic       clk_en_in,
    input wire logic       host_cs_in,
    input wire logic       host_wr_in,
    input wire logic       host_rd_in,
    input wire logic [7:0] host_addr_in,
    input wire logic [7:0] host_wdata_in,
    input wire logic       bus_off_in,
    input wire logic       host_rvalid_out,
    input wire logic [7:0] operating_config_out,
    input wire logic [7:0] command_strobe_out,
    input wire logic [7:0] rx_buffer_start_out,
    input wire logic [7:0] clock_divider_out,
    input wire logic       init_hold_out,
    input wire logic       frame_abort_out,
    input wire logic       resume_out
);
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (sys_rst_in);
    logic       wr_at;
    logic [6:0] ofs;
    assign wr_at = clk_en_in & host_cs_in & host_wr_in;
    // Top address bit dropped, so aliases are checked too
    assign ofs = host_addr_in[6:0];
    sequence s_abort;
        frame_abort_out ##1 !frame_abort_out;
    endsequence
    sequence s_resume;
        resume_out ##1 !resume_out;
    endsequence
    a_rvalid_next: assert property (clk_en_in & host_cs_in & host_rd_in |=> host_rvalid_out)
        else $error("read answer missing");
    a_reset_load: assert property ($fell(sys_rst_in) |->
        operating_config_out == MODE_RESET && clock_divider_out == CLKDIV_RESET
        && rx_buffer_start_out == RXB_START_RESET)
        else $error("reset values wrong");
    a_busoff_enter: assert property (clk_en_in & bus_off_in |-> ##[1:2] init_hold_out)
        else $error("bus off did not enter reset mode");
    a_abort_pulse: assert property ($rose(init_hold_out) |-> ##[0:1] s_abort)
        else $error("abort pulse missing");
    a_resume_pulse: assert property ($fell(init_hold_out) |-> s_resume)
        else $error("resume pulse missing");
    // Mode seen at the write edge shows on init_hold_out one cycle later
    a_rxstart_lock: assert property (
        (wr_at && ofs == OFS_RXB_START) ##1 !init_hold_out
        |=> $stable(rx_buffer_start_out))
        else $error("start address written in operating mode");
    a_clkdiv_lock: assert property (
        (wr_at && ofs == OFS_CLKDIV) ##1 !init_hold_out
        |=> (clock_divider_out & CLKDIV_LOCKED) == ($past(clock_divider_out) & CLKDIV_LOCKED))
        else $error("locked divider bits changed");
    // Register then output stage: a write shows two edges later
    a_clkdiv_open: assert property (
        wr_at && ofs == OFS_CLKDIV |-> ##2
        (clock_divider_out & ~CLKDIV_LOCKED) == ($past(host_wdata_in, 2) & ~CLKDIV_LOCKED))
        else $error("open divider bits not written");
    a_mode_write: assert property (
        wr_at && ofs == OFS_MODE && !bus_off_in |-> ##2
        (operating_config_out & 8'hEF) == ($past(host_wdata_in, 2) & 8'h0F))
        else $error("mode write lost");
    a_cmd_refused: assert property (
        (wr_at && ofs == OFS_CMD) ##1 init_hold_out
        |-> command_strobe_out == 8'h00)
        else $error("command taken in reset mode");
    a_cmd_accept: assert property (
        (wr_at && ofs == OFS_CMD && !bus_off_in) ##1 !init_hold_out
        |-> command_strobe_out == ($past(host_wdata_in) & 8'h1F))
        else $error("command lost in operating mode");
endmodule : ccum_regmap_chk
bind ccum_regmap ccum_regmap_chk u_chk (.ref_clk_in, .sys_rst_in, .clk_en_in, .host_cs_in,
    .host_wr_in, .host_rd_in, .host_addr_in, .host_wdata_in, .bus_off_in, .host_rvalid_out,
    .operating_config_out, .command_strobe_out, .rx_buffer_start_out, .clock_divider_out,
    .init_hold_out, .frame_abort_out, .resume_out);

// file: testbench/test_ccum_regmap.sv
// Self-checking bench of the upper register map
`timescale 1ns/1ps
module test_ccum_regmap;
    import ccum_pkg::*;
    logic       clk, rst, bus_off, cs, wr, rd, ih, ce;
    logic [7:0] addr, wdata, rdata, cstate, q, a, d, cd, rs, fl;
    logic [7:0] mem [80];
    logic [6:0] ptr, len;
    int         num_errors, num_checks, seed;
    ccum_regmap uut (.ref_clk_in(clk), .sys_rst_in(rst), .clk_en_in(ce), .host_cs_in(cs),
        .host_wr_in(wr), .host_rd_in(rd), .host_addr_in(addr), .host_wdata_in(wdata),
        .bus_off_in(bus_off), .core_state_in(cstate), .core_flags_in(fl),
        .rx_read_ptr_in(ptr), .rx_msg_len_in(len), .rx_msg_count_in(cstate),
        .core_ram_we_in(1'b0), .core_ram_addr_in(7'h00), .core_ram_wdata_in(8'h00),
        .host_rdata_out(rdata), .host_rvalid_out(), .operating_config_out(),
        .command_strobe_out(), .rx_buffer_start_out(), .clock_divider_out(),
        .init_hold_out(ih), .frame_abort_out(), .resume_out());
    ccum_host_model host (.ref_clk_in(clk), .host_rdata_in(rdata), .host_cs_out(cs),
        .host_wr_out(wr), .host_rd_out(rd), .host_addr_out(addr), .host_wdata_out(wdata));
    function automatic logic [7:0] f_cd(input logic [7:0] o, input logic [7:0] w);
        return (o & CLKDIV_LOCKED) | (w & ~CLKDIV_LOCKED);
    endfunction : f_cd
    task check(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask : check
    task rdc(input logic [7:0] ad, input logic [7:0] e);
        host.xfer(1'b0, ad, 8'h00, q);
        check(q, e);
    endtask : rdc
    task wr8(input logic [7:0] ad, input logic [7:0] dd);
        host.xfer(1'b1, ad, dd, q);
    endtask : wr8
    task final_report;
        $display("Checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : final_report
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    initial begin
        repeat (3000) @(posedge clk);
        num_errors++;
        final_report;
    end
    initial begin
        seed = 32'h3B2506D1;
        {rst, bus_off, ptr, len} = {1'b1, 1'b0, 7'h00, 7'h03};
        {ce, fl} = {1'b1, 8'h00};
        cstate = 8'($random(seed));
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        rdc(8'h00, MODE_RESET);
        rdc(8'h02, STATE_RESET);
        rdc(8'h03, 8'h00);
        rdc(8'h80, MODE_RESET);
        wr8(8'h01, 8'hFF);
        rdc(8'h01, 8'h00);
        rdc(8'h9D, cstate);
        for (int i = 0; i < 12; i++) begin
            a = 8'(8'd37 + ($unsigned($random(seed)) % 75));
            d = 8'($random(seed));
            mem[a - 8'd32] = d;
            wr8(a | 8'h80, d);
            rdc(a, d);
        end
        wr8(8'h20, 8'h05);
        wr8(8'h23, 8'hA5);
        wr8(8'h24, 8'h5A);
        rs = 8'($random(seed));
        wr8(8'h1E, rs);
        rdc(8'h1E, rs);
        cd = 8'($random(seed));
        wr8(8'h1F, cd);
        rdc(8'h1F, cd);
        // Long-frame header at RAM 8, its data 7/8 at RAM 19/20
        wr8(8'h28, 8'h88);
        wr8(8'h33, 8'hC3);
        wr8(8'h34, 8'h3C);
        mem[8] = 8'h88;
        mem[19] = 8'hC3;
        mem[20] = 8'h3C;
        // Frozen clock enable must swallow a legal write
        @(posedge clk) ce <= 1'b0;
        wr8(8'h1E, ~rs);
        @(posedge clk) ce <= 1'b1;
        rdc(8'h1E, rs);
        wr8(8'h00, 8'h08);
        rdc(8'h00, 8'h08);
        check({7'h00, ih}, 8'h00);
        rdc(8'h82, cstate);
        wr8(8'h01, 8'hFF);
        wr8(8'h1E, ~rs);
        rdc(8'h1E, rs);
        d = 8'($random(seed));
        wr8(8'h9F, d);
        rdc(8'h1F, f_cd(cd, d));
        wr8(a, ~mem[a - 8'd32]);
        rdc(a, mem[a - 8'd32]);
        // Base frame at pointer 0 of length 3: window shows RAM 3 and 4
        rdc(8'h1B, 8'hA5);
        rdc(8'h1C, 8'h5A);
        @(posedge clk) ptr <= 7'h08;
        rdc(8'h1B, 8'hC3);
        rdc(8'h9C, 8'h3C);
        wr8(8'h1C, 8'h96);
        rdc(8'h6C, 8'h96);
        @(posedge clk) fl <= 8'hFF;
        @(posedge clk) fl <= 8'h00;
        rdc(8'h03, 8'hFF);
        rdc(8'h03, 8'h00);
        @(posedge clk) fl <= 8'hFF;
        @(posedge clk) fl <= 8'h00;
        @(posedge clk) bus_off <= 1'b1;
        @(posedge clk) bus_off <= 1'b0;
        rdc(8'h00, 8'h09);
        rdc(8'h02, (STATE_RESET & ~STATE_KEEP_MASK) | (cstate & STATE_KEEP_MASK));
        rdc(8'h03, FLAGS_KEEP_MASK);
        final_report;
    end
endmodule : test_ccum_regmap
